// ---- logic/adc_seq_pkg.sv ----
package adc_seq_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] CONV_CFG_IDX = 8'h05;
   localparam logic [7:0] IRQ_EN_IDX = 8'h06;
   localparam logic [7:0] TRIG_MODE_IDX = 8'h08;
   localparam logic [7:0] CHAN_SEL_IDX = 8'h10;
   localparam logic [7:0] STATUS_IDX = 8'h11;
   localparam logic [7:0] COMMAND_IDX = 8'h12;
   localparam logic [7:0] CONV_CFG_RST = 8'h00;
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] TRIG_MODE_RST = 8'h00;
   localparam logic [7:0] CHAN_SEL_RST = 8'h00;
   // converter config bits
   localparam int SERIAL_START_BIT = 0;
   localparam int FIFO_EN_BIT = 1;
   // interrupt enable bit for scan data ready
   localparam int SCAN_RDY_IE_BIT = 1;
   // command bits (self clearing)
   localparam int CMD_READ_BIT = 0;
   localparam int CMD_SCAN_BIT = 1;
   localparam int CMD_STOP_BIT = 2;
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_MANUAL = 3'h2;
   localparam logic [2:0] MODE_MANUAL_DLY = 3'h3;
   localparam logic [2:0] MODE_AUTO_MANCH = 3'h4;
   localparam logic [2:0] MODE_SINGLE_SCAN = 3'h5;
   localparam logic [2:0] MODE_MULTI_SCAN = 3'h6;
   localparam logic [2:0] LAST_CHANNEL = 3'h7;
   localparam logic [2:0] FIFO_LAST = 3'h7;
   // conversion clock timing, counted in half periods
   localparam int CORE_PERIOD_NS = 10;
   localparam int CONVERSION_CLOCK_HALF_NS = 125;
   localparam int HALF_CYC = CONVERSION_CLOCK_HALF_NS / CORE_PERIOD_NS;
   localparam logic [3:0] HALF_CYC_LAST = 4'(HALF_CYC - 1);
   localparam logic [5:0] ACQ_HALVES = 6'd17;
   localparam logic [5:0] CONV_HALVES = 6'd27;
   localparam logic [5:0] GAP_HALVES = 6'd36;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ACQ = 4'b0010,
      ST_CONV = 4'b0100,
      ST_GAP = 4'b1000
   } seq_state_t;

   typedef struct packed {
      logic run;
      logic gap;
      logic converting;
      logic acquiring;
   } seq_status_t;
endpackage

// ---- logic/adc_trigger_scan_sequencer.sv ----
`timescale 1ns/1ps
// Operation
// RL1: mode field of trigger mode register picks manual trigger modes 2 and 3
// RL2: manual modes start on start pin low, or serial read when bit 0 set
// RL3: mode 2 follows any host channel, converting only on request
// RL4: mode 3 moves multiplexer to next channel when sampling ends
// RL5: config bit 1 enables result FIFO, else bypassed, in all modes
// RL6: host sets first channel, mode 3, second channel, then pulses start
// RL7: host configures all channels before enabling auto modes
// RL8: mode 5 scans selected channels once, serial command starts next scan
// RL9: mode 5 with FIFO restarts FIFO contents at each new scan
// RL10: mode 6 cycles start channel up to 7, wraps, until stop or mode change
// RL11: mode 6 with FIFO and enable bit 1 raises scan data ready
// RL12: mode 6 FIFO full after eight conversions, later ones overwrite
// RL13: mode 4 self triggers, host picks channel, delayed switch always on
// RL14: mode 4 host sets second channel within 10 us of mode select
// RL15: start pin works independently of chip select
// RL16: acquire 8.5 conversion clocks, then convert for 13.5
// RL17: host spaces conversion starts at least 40 conversion clocks
// RL18: auto modes restart 18 conversion clocks after conversion end
// RL19: mode codes 0 idle, 2..6 as listed, 1 and 7 reserved
// RL20: timing runs from a 4 MHz conversion clock; code uses 12 core cycles (120 ns) per half period, about 4.17 MHz
// RL21: reserved modes act as idle, no conversions
// RL22: start pin ignored in idle and auto trigger modes
module adc_trigger_scan_sequencer
   import adc_seq_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic [9:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic i_conv_start_n,
   output logic [2:0] o_mux_channel,
   output seq_status_t o_status,
   output logic o_fifo_enable,
   output logic o_conv_done,
   output logic o_fifo_restart,
   output logic o_scan_ready
);
   logic ack_q;
   logic wr_en;
   logic [7:0] idx;
   logic [7:0] conv_cfg_q;
   logic [7:0] irq_en_q;
   logic [7:0] trig_mode_q;
   logic [7:0] chan_sel_q;
   logic [2:0] cmd_q;
   logic mode_wr_q;
   logic [2:0] pin_sync_q;
   logic pin_fall;
   logic [3:0] div_q;
   logic tick;
   logic [5:0] cnt_q;
   seq_state_t state_q;
   logic run_q;
   logic [2:0] mux_q;
   logic [2:0] fifo_cnt_q;
   logic [2:0] mode;
   logic manual;
   logic auto_mode;
   logic delay_mux;
   logic manual_start;
   logic acq_end;
   logic conv_end;
   logic gap_end;

   function automatic logic is_auto(input logic [2:0] m);
      is_auto = (m == MODE_AUTO_MANCH) || (m == MODE_SINGLE_SCAN) ||
         (m == MODE_MULTI_SCAN);
   endfunction

   assign idx = i_address[9:2];
   assign o_waitrequest = (i_read | i_write) & ~ack_q;
   assign wr_en = i_write & ack_q;
   assign mode = trig_mode_q[2:0];
   // RL19 RL21 mode decode
   assign manual = (mode == MODE_MANUAL) || (mode == MODE_MANUAL_DLY);
   assign auto_mode = is_auto(mode);
   // RL13 delay always on
   assign delay_mux = (mode == MODE_MANUAL_DLY) || (mode == MODE_AUTO_MANCH);
   assign pin_fall = pin_sync_q[2] & ~pin_sync_q[1];
   // RL2 trigger source select
   assign manual_start = manual && (conv_cfg_q[SERIAL_START_BIT] ?
      cmd_q[CMD_READ_BIT] : pin_fall);
   // one counter serves all phases, so each end must match its own state
   assign acq_end = tick && state_q == ST_ACQ && cnt_q == ACQ_HALVES - 6'd1;
   assign conv_end = tick && state_q == ST_CONV && cnt_q == CONV_HALVES - 6'd1;
   assign gap_end = tick && state_q == ST_GAP && cnt_q == GAP_HALVES - 6'd1;
   // RL5 fifo enable
   assign o_fifo_enable = conv_cfg_q[FIFO_EN_BIT];
   assign o_mux_channel = mux_q;
   assign o_status = '{run: run_q, gap: (state_q == ST_GAP),
      converting: (state_q == ST_CONV), acquiring: (state_q == ST_ACQ)};

   // one wait cycle per access, answer at the second edge
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (i_read | i_write) & ~ack_q;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_readdata <= 32'h0;
      end else if (i_read && !ack_q) begin
         unique case (idx)
            CONV_CFG_IDX: o_readdata <= {24'h0, conv_cfg_q};
            IRQ_EN_IDX: o_readdata <= {24'h0, irq_en_q};
            TRIG_MODE_IDX: o_readdata <= {24'h0, trig_mode_q};
            CHAN_SEL_IDX: o_readdata <= {24'h0, chan_sel_q};
            STATUS_IDX: o_readdata <= {25'h0, fifo_cnt_q, o_status};
            default: o_readdata <= 32'h0;
         endcase
      end
   end

   // RL1 mode register write
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         conv_cfg_q <= CONV_CFG_RST;
         irq_en_q <= IRQ_EN_RST;
         trig_mode_q <= TRIG_MODE_RST;
         chan_sel_q <= CHAN_SEL_RST;
         mode_wr_q <= 1'b0;
         cmd_q <= 3'h0;
      end else begin
         mode_wr_q <= wr_en && (idx == TRIG_MODE_IDX);
         cmd_q <= 3'h0;
         if (wr_en) begin
            unique case (idx)
               CONV_CFG_IDX: conv_cfg_q <= i_writedata[7:0];
               IRQ_EN_IDX: irq_en_q <= i_writedata[7:0];
               TRIG_MODE_IDX: trig_mode_q <= i_writedata[7:0];
               CHAN_SEL_IDX: chan_sel_q <= i_writedata[7:0];
               COMMAND_IDX: cmd_q <= i_writedata[2:0];
               default: ;
            endcase
         end
      end
   end

   // RL15 pin sampled alone, no chip select gating
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_sync_q <= 3'h7;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], i_conv_start_n};
      end
   end

   // RL20 half conversion clock enable
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_q <= 4'h0;
      end else begin
         div_q <= (div_q == HALF_CYC_LAST) ? 4'h0 : div_q + 4'h1;
      end
   end
   assign tick = (div_q == HALF_CYC_LAST);

   // RL8 run flag for auto modes
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_q <= 1'b0;
      end else if (mode_wr_q) begin
         run_q <= auto_mode;
      end else if (cmd_q[CMD_STOP_BIT] || !auto_mode) begin
         run_q <= 1'b0;
      end else if (cmd_q[CMD_SCAN_BIT] && mode == MODE_SINGLE_SCAN) begin
         run_q <= 1'b1;
      end else if (conv_end && mode == MODE_SINGLE_SCAN &&
            mux_q == LAST_CHANNEL) begin
         run_q <= 1'b0;
      end
   end

   // RL16 acquire then convert
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= ST_IDLE;
         cnt_q <= 6'h0;
      end else if (mode_wr_q) begin
         // a mode change abandons any conversion in flight
         state_q <= ST_IDLE;
         cnt_q <= 6'h0;
      end else begin
         if (tick) begin
            cnt_q <= cnt_q + 6'h1;
         end
         unique case (state_q)
            ST_IDLE: begin
               cnt_q <= 6'h0;
               // RL22 pin ignored outside manual
               if (manual_start || (run_q && auto_mode)) begin
                  state_q <= ST_ACQ;
               end
            end
            ST_ACQ: begin
               if (acq_end) begin
                  state_q <= ST_CONV;
                  cnt_q <= 6'h0;
               end
            end
            ST_CONV: begin
               if (conv_end) begin
                  cnt_q <= 6'h0;
                  // RL18 auto restart gap
                  state_q <= (run_q && !cmd_q[CMD_STOP_BIT] &&
                     !(mode == MODE_SINGLE_SCAN && mux_q == LAST_CHANNEL))
                     ? ST_GAP : ST_IDLE;
               end
            end
            ST_GAP: begin
               if (!run_q) begin
                  state_q <= ST_IDLE;
               end else if (gap_end) begin
                  state_q <= ST_CONV;
                  cnt_q <= 6'h0;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // multiplexer channel control
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mux_q <= 3'h0;
      end else if (mode_wr_q ||
            (cmd_q[CMD_SCAN_BIT] && mode == MODE_SINGLE_SCAN)) begin
         mux_q <= chan_sel_q[2:0];
      end else if (mode == MODE_MANUAL && state_q == ST_IDLE) begin
         // RL3 free channel choice
         mux_q <= chan_sel_q[2:0];
      end else if (delay_mux && (acq_end || gap_end)) begin
         // RL4 switch when sampling ends
         mux_q <= chan_sel_q[2:0];
      end else if (conv_end && (mode == MODE_SINGLE_SCAN ||
            mode == MODE_MULTI_SCAN)) begin
         // RL10 wrap to start channel
         mux_q <= (mux_q == LAST_CHANNEL) ? chan_sel_q[2:0] : mux_q + 3'h1;
      end
   end

   // RL12 eight results fill the FIFO
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fifo_cnt_q <= 3'h0;
         o_conv_done <= 1'b0;
         o_fifo_restart <= 1'b0;
         o_scan_ready <= 1'b0;
      end else begin
         o_conv_done <= (state_q == ST_CONV) && conv_end && !mode_wr_q;
         // RL9 new scan restarts FIFO
         o_fifo_restart <= conv_cfg_q[FIFO_EN_BIT] && (mode_wr_q ||
            (cmd_q[CMD_SCAN_BIT] && mode == MODE_SINGLE_SCAN));
         // RL11 scan ready pulse
         o_scan_ready <= o_conv_done && mode == MODE_MULTI_SCAN &&
            conv_cfg_q[FIFO_EN_BIT] && irq_en_q[SCAN_RDY_IE_BIT] &&
            fifo_cnt_q == FIFO_LAST;
         if (o_fifo_restart) begin
            fifo_cnt_q <= 3'h0;
         end else if (o_conv_done && conv_cfg_q[FIFO_EN_BIT]) begin
            fifo_cnt_q <= fifo_cnt_q + 3'h1;
         end
      end
   end

   property p_acq_len;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(state_q == ST_ACQ) && !mode_wr_q |->
         (state_q == ST_ACQ) [*8] ##1 (cnt_q < ACQ_HALVES);
   endproperty
   a_acq_len: assert property (p_acq_len) // RL16
      else $error("acquisition ended early");

   property p_acq_to_conv;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      state_q == ST_ACQ && acq_end && !mode_wr_q |=> state_q == ST_CONV;
   endproperty
   a_acq_to_conv: assert property (p_acq_to_conv) // RL16
      else $error("no conversion after acquisition");

   property p_manual_start;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      state_q == ST_IDLE && manual && !mode_wr_q && pin_fall &&
         !conv_cfg_q[SERIAL_START_BIT] |=> state_q == ST_ACQ;
   endproperty
   a_manual_start: assert property (p_manual_start) // RL2
      else $error("start pin did not start a conversion");

   property p_pin_ignored;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      state_q == ST_IDLE && !manual && !run_q |=> state_q == ST_IDLE;
   endproperty
   a_pin_ignored: assert property (p_pin_ignored) // RL22
      else $error("conversion started outside manual modes");

   property p_reserved;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      !manual && !auto_mode && $past(!manual && !auto_mode) |->
         state_q == ST_IDLE;
   endproperty
   a_reserved: assert property (p_reserved) // RL21
      else $error("busy in idle or reserved mode");

   property p_gap_auto;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      state_q == ST_GAP && !mode_wr_q |-> auto_mode;
   endproperty
   a_gap_auto: assert property (p_gap_auto) // RL18
      else $error("auto gap in a manual mode");

   property p_mode2_mux;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      mode == MODE_MANUAL && state_q == ST_IDLE && !mode_wr_q |=>
         mux_q == $past(chan_sel_q[2:0]);
   endproperty
   a_mode2_mux: assert property (p_mode2_mux) // RL3
      else $error("mode 2 channel not followed");

   property p_delay_mux;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      delay_mux && state_q == ST_ACQ && acq_end && !mode_wr_q |=>
         mux_q == $past(chan_sel_q[2:0]);
   endproperty
   a_delay_mux: assert property (p_delay_mux) // RL4
      else $error("delayed switch missed");

   property p_wrap;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      mode == MODE_MULTI_SCAN && conv_end && state_q == ST_CONV &&
         !mode_wr_q && mux_q == LAST_CHANNEL |=>
         mux_q == $past(chan_sel_q[2:0]);
   endproperty
   a_wrap: assert property (p_wrap) // RL10
      else $error("multi scan did not wrap");

   property p_scan_ready;
      @(posedge i_core_clk) disable iff (!i_rst_b)
      o_scan_ready |-> $past(o_conv_done) && mode == MODE_MULTI_SCAN &&
         irq_en_q[SCAN_RDY_IE_BIT];
   endproperty
   a_scan_ready: assert property (p_scan_ready) // RL11
      else $error("spurious scan ready");

   c_manual: cover property (@(posedge i_core_clk)
      manual && state_q == ST_ACQ ##[1:300] o_conv_done);
   c_gap: cover property (@(posedge i_core_clk)
      state_q == ST_GAP ##[1:500] state_q == ST_CONV);
   c_ready: cover property (@(posedge i_core_clk) o_scan_ready);
endmodule

// ---- sim/host_start_model.sv ----
`timescale 1ns/1ps
module host_start_model (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_req,
   output logic o_conv_start_n
);
   logic pend_q;
   logic [10:0] gap_q;
   logic [3:0] low_q;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pend_q <= 1'b0;
         gap_q <= 11'h3e8;
         low_q <= 4'h0;
      end else begin
         if (i_req)
            pend_q <= 1'b1;
         if (low_q != 4'h0)
            low_q <= low_q - 4'h1;
         // early requests wait out 40 conversion clocks
         if (pend_q && gap_q >= 11'h3e8) begin
            pend_q <= 1'b0;
            gap_q <= 11'h0;
            low_q <= 4'h8;
         end else if (gap_q < 11'h3e8) begin
            gap_q <= gap_q + 11'h1;
         end
      end
   end
   assign o_conv_start_n = (low_q == 4'h0);
endmodule

// ---- sim/test_adc_trigger_scan_sequencer.sv ----
`timescale 1ns/1ps
module test_adc_trigger_scan_sequencer;
   import adc_seq_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [9:0] adr = 10'h0;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic wt;
   logic req = 1'b0;
   logic cs_n;
   logic [2:0] mux;
   seq_status_t st;
   logic fen, dn, frs, srdy;
   logic cprev = 1'b0;
   logic [2:0] chans[$];
   logic [2:0] bad[3] = '{MODE_IDLE, 3'h1, 3'h7};
   logic [31:0] r;
   int failures = 0;
   int checks = 0;
   int acq_n, conv_n, done_n, rdy_n, rs_n, cyc, lastd, per;
   always #5 clk = ~clk;
   adc_trigger_scan_sequencer i_adc_trigger_scan_sequencer (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_address(adr),
      .i_read(rd_s), .i_write(wr_s), .i_writedata(wd),
      .o_readdata(rdat), .o_waitrequest(wt), .i_conv_start_n(cs_n),
      .o_mux_channel(mux), .o_status(st), .o_fifo_enable(fen),
      .o_conv_done(dn), .o_fifo_restart(frs), .o_scan_ready(srdy));
   host_start_model i_host_start_model (.i_core_clk(clk),
      .i_rst_b(rst_b), .i_req(req), .o_conv_start_n(cs_n));
   always @(posedge clk) begin
      cyc++;
      if (st.acquiring === 1'b1) acq_n++;
      if (st.converting === 1'b1) conv_n++;
      if (srdy === 1'b1) rdy_n++;
      if (frs === 1'b1) rs_n++;
      if (dn === 1'b1) begin
         done_n++;
         per = cyc - lastd;
         lastd = cyc;
      end
      if (st.converting === 1'b1 && !cprev) chans.push_back(mux);
      cprev = (st.converting === 1'b1);
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] ix,
                      input logic [31:0] d);
      @(posedge clk);
      adr <= {ix, 2'b00};
      wd <= d;
      wr_s <= w;
      rd_s <= ~w;
      do @(posedge clk); while (wt !== 1'b0);
      r = rdat;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] ix,
                        input logic [31:0] e);
      bus(1'b0, ix, 32'h0);
      chk(nm, e, r);
   endtask
   task automatic clr();
      acq_n = 0;
      conv_n = 0;
      done_n = 0;
      rdy_n = 0;
      rs_n = 0;
      chans.delete();
   endtask
   task automatic pulse();
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
   endtask
   task automatic wdone(input int n);
      int k;
      k = 0;
      while (done_n < n && k < 20000) begin
         @(posedge clk);
         k++;
      end
      chk("done count", n, done_n);
   endtask
   task automatic note(input string nm);
      $display("test %s finished", nm);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rdchk("conv cfg", CONV_CFG_IDX, {24'h0, CONV_CFG_RST});
      rdchk("irq en", IRQ_EN_IDX, {24'h0, IRQ_EN_RST});
      rdchk("trig mode", TRIG_MODE_IDX, {24'h0, TRIG_MODE_RST});
      rdchk("chan sel", CHAN_SEL_IDX, {24'h0, CHAN_SEL_RST});
      bus(1'b1, 8'h3f, 32'h5a);
      rdchk("unmapped", 8'h3f, 32'h0);
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_MANUAL});
      rdchk("trig mode rw", TRIG_MODE_IDX, {29'h0, MODE_MANUAL});
      note("registers");
      // a start pulse is ignored in idle and reserved codes
      foreach (bad[i]) begin
         bus(1'b1, TRIG_MODE_IDX, {29'h0, bad[i]});
         clr();
         pulse();
         repeat (1200) @(posedge clk);
         chk("refused start", 0, acq_n + conv_n);
      end
      note("refusals");
      bus(1'b1, CHAN_SEL_IDX, 32'h3);
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_MANUAL});
      clr();
      pulse();
      wdone(1);
      chk("mux", 32'h3, {29'h0, mux});
      chk("acq span", 1, acq_n inside {[193:204]});
      chk("conv span", 1, conv_n inside {[320:328]});
      bus(1'b1, CONV_CFG_IDX, 32'h1);
      clr();
      pulse();
      repeat (1200) @(posedge clk);
      chk("pin with serial", 0, acq_n);
      bus(1'b1, COMMAND_IDX, 32'h1);
      wdone(1);
      note("mode 2");
      bus(1'b1, CONV_CFG_IDX, 32'h0);
      bus(1'b1, CHAN_SEL_IDX, 32'h1);
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_MANUAL_DLY});
      bus(1'b1, CHAN_SEL_IDX, 32'h2);
      clr();
      pulse();
      repeat (100) @(posedge clk);
      chk("mux in sampling", 32'h1, {29'h0, mux});
      wdone(1);
      chk("mux after sampling", 32'h2, {29'h0, mux});
      note("mode 3");
      bus(1'b1, CONV_CFG_IDX, 32'h2);
      repeat (2) @(posedge clk);
      chk("fifo on", 1, fen);
      bus(1'b1, IRQ_EN_IDX, 32'h2);
      bus(1'b1, CHAN_SEL_IDX, 32'h4);
      clr();
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_MULTI_SCAN});
      wdone(8);
      repeat (5) @(posedge clk);
      chk("scan ready", 1, rdy_n);
      chk("fifo restart", 1, rs_n);
      chk("auto period", 1, per inside {[752:760]});
      bus(1'b1, COMMAND_IDX, 32'h4);
      repeat (20) @(posedge clk);
      chk("run after stop", 0, st.run);
      bus(1'b1, CONV_CFG_IDX, 32'h0);
      repeat (2) @(posedge clk);
      chk("fifo off", 0, fen);
      clr();
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_MULTI_SCAN});
      wdone(5);
      for (int i = 0; i < 5; i++)
         chk("scan chan", 4 + i % 4, chans[i]);
      chk("no ready", 0, rdy_n);
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_IDLE});
      repeat (20) @(posedge clk);
      chk("run after mode", 0, st.run);
      note("mode 6");
      bus(1'b1, CONV_CFG_IDX, 32'h2);
      bus(1'b1, CHAN_SEL_IDX, 32'h5);
      clr();
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_SINGLE_SCAN});
      wdone(3);
      repeat (2000) @(posedge clk);
      chk("single scan", 3, done_n);
      chk("run after scan", 0, st.run);
      rdchk("status", STATUS_IDX, 32'h30);
      bus(1'b1, COMMAND_IDX, 32'h2);
      wdone(6);
      chk("scan restart", 2, rs_n);
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_IDLE});
      note("mode 5");
      bus(1'b1, CONV_CFG_IDX, 32'h0);
      bus(1'b1, CHAN_SEL_IDX, 32'h2);
      clr();
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_AUTO_MANCH});
      bus(1'b1, CHAN_SEL_IDX, 32'h6);
      wdone(3);
      chk("manual chan", 32'h6, chans[2]);
      bus(1'b1, TRIG_MODE_IDX, {29'h0, MODE_IDLE});
      note("mode 4");
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      end_sim();
   end
endmodule
